// ===== difm_defines.vh
// Purpose: constants for the digital input function mapper
// Assumes: 40 MHz ref_clk, AHB-Lite register access
// Notes: offsets are byte addresses on a 32-bit bus
`ifndef DIFM_DEFINES_VH
`define DIFM_DEFINES_VH

`define DIFM_NUM_DIN 4
`define DIFM_NUM_FN 22

// Register byte offsets
`define DIFM_OFS_DIN0 8'h00
`define DIFM_OFS_DIN1 8'h04
`define DIFM_OFS_DIN2 8'h08
`define DIFM_OFS_DIN3 8'h0c
`define DIFM_OFS_CWSEL 8'h10
`define DIFM_OFS_MODE 8'h14
`define DIFM_OFS_KVI 8'h18
`define DIFM_OFS_SWCW 8'h1c
`define DIFM_OFS_STAT 8'h20
`define DIFM_OFS_FNACT 8'h24
`define DIFM_TBL_SPD 3'h2
`define DIFM_TBL_POS 3'h3
`define DIFM_TBL_GNUM 3'h4
`define DIFM_TBL_GDEN 3'h5

// Reset values
`define DIFM_RST_CWSEL 16'h000f
`define DIFM_RST_MODE0 8'hfd
`define DIFM_RST_MODE1 8'hfc
`define DIFM_RST_KVI 16'h0000
`define DIFM_RST_SWCW 16'h0000

// Control word values and bits
`define DIFM_CW_DISABLED 16'h0006
`define DIFM_CW_ENABLED 16'h000f
`define DIFM_CW_QSTOP_BIT 2
`define DIFM_CW_NEWSP_BIT 4
`define DIFM_CW_RSTERR_BIT 7

// Working modes
`define DIFM_MODE_HOMING 8'h06
`define DIFM_MODE_SPD_P 8'h03
`define DIFM_MODE_SPD_N 8'hfd
`define DIFM_MODE_TRQ_P 8'h04
`define DIFM_MODE_TRQ_N 8'hfc

// Function vector bit positions
`define DIFM_FN_ENABLE 0
`define DIFM_FN_RSTERR 1
`define DIFM_FN_MODESEL 2
`define DIFM_FN_KVIOFF 3
`define DIFM_FN_PLIM 4
`define DIFM_FN_NLIM 5
`define DIFM_FN_HOME 6
`define DIFM_FN_INVDIR 7
`define DIFM_FN_SPD0 8
`define DIFM_FN_SPD1 9
`define DIFM_FN_POS0 10
`define DIFM_FN_POS1 11
`define DIFM_FN_QSTOP 12
`define DIFM_FN_HOMEGO 13
`define DIFM_FN_ACTCMD 14
`define DIFM_FN_SPD2 15
`define DIFM_FN_POS2 16
`define DIFM_FN_MF0 17
`define DIFM_FN_MF1 18
`define DIFM_FN_MF2 19
`define DIFM_FN_GAIN0 20
`define DIFM_FN_GAIN1 21

// Code layout: bit 15 selects the extended group
`define DIFM_CODE_EXT_BIT 15
`define DIFM_BASE_W 15
`define DIFM_EXT_W 7

`endif

// ===== difm_props.sv
// Purpose: port checks of bus timing and homing on difm_top
// Assumes: one clock, rst synchronous active high
// Notes: effects that hang on register contents are judged by the bench
`timescale 1ns/10ps
module difm_props (
  input wire ref_clk, // Clock
  input wire rst, // Reset
  input wire hsel, // Select
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write
  input wire hready, // Bus ready
  input wire [31:0] hrdata, // Read data
  input wire hreadyout, // Slave ready
  input wire hresp, // Response
  input wire [7:0] work_mode, // Mode
  input wire homing_start // Homing pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rd = hsel && htrans[1] && hready && !hwrite;
  wire wr = hsel && htrans[1] && hready && hwrite;
  reg [7:0] last_q;
  // Mode in force before homing took over
  always @(posedge ref_clk) begin
    if (rst)
      last_q <= 8'hfd;
    else if (work_mode != 8'h06)
      last_q <= work_mode;
  end
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  read_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (wr |=> hreadyout)
    else $error("write stalled");
  wait_cause_a: assert property (!hreadyout |-> $past(rd))
    else $error("stall without read");
  rdata_hold_a: assert property (!$past(rd, 2) |-> $stable(hrdata))
    else $error("read data moved");
  home_pulse_a: assert property (homing_start |=> !homing_start)
    else $error("homing start too long");
  home_mode_a: assert property (homing_start |-> ##[0:3] work_mode == 8'h06)
    else $error("homing mode missing");
  mode_back_a: assert property (($past(work_mode) == 8'h06) &&
    (work_mode != 8'h06) |-> work_mode == last_q)
    else $error("mode not restored");
endmodule
bind difm_top difm_props difm_props_i (.ref_clk, .rst, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .work_mode, .homing_start);

// ===== difm_switch.sv
// Purpose: switch field in front of the digital inputs
// Assumes: contacts actuated on command of the bench
// Notes: normally closed contacts read one at rest
`timescale 1ns/10ps
module difm_switch (
  input wire ref_clk, // Clock
  input wire [3:0] press, // Contacts actuated
  input wire [3:0] nc, // Contacts wired normally closed
  output reg [3:0] din // Levels at the inputs
);
  initial din = 4'h0;
  always @(posedge ref_clk) begin
    din <= press ^ nc;
  end
endmodule

// ===== difm_table.v
// Purpose: eight-entry table with registered read port
// Assumes: one write port from the register bus
// Notes: read data lags the read index by one clock
`timescale 1ns/10ps
module difm_table (
  input wire ref_clk, // Control clock
  input wire rst, // Synchronous reset, active high
  input wire wr_en, // Write strobe
  input wire [2:0] wr_idx, // Write entry
  input wire [31:0] wr_data, // Write value
  input wire [2:0] rd_idx, // Read entry
  output reg [31:0] rd_data // Registered entry value
);
  reg [31:0] mem [0:7];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule

// ===== difm_top.v
// Purpose: maps four digital inputs to control word, mode, gains and gear
// Assumes: inputs already polarity-corrected and synchronous to ref_clk
// Notes: registers reached over AHB-Lite, reads take one wait state
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`include "difm_defines.vh"

module difm_top (
  input wire ref_clk, // 40 MHz control clock
  input wire rst, // Synchronous reset, active high
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size, word only
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output reg [31:0] hrdata, // AHB read data
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response, always OKAY
  input wire [3:0] din, // Conditioned digital inputs
  input wire home_found, // Motion core found origin, pulse
  output reg [15:0] ctrl_word, // Effective control word
  output reg [7:0] work_mode, // Effective working mode
  output reg [15:0] kvi_eff, // Speed-loop integral gain in use
  output reg fwd_inhibit, // Positive direction blocked
  output reg rev_inhibit, // Negative direction blocked
  output reg home_ref, // Origin switch level for homing
  output reg homing_start, // One-cycle homing request
  output reg [31:0] speed_cmd, // Speed command from table
  output reg [31:0] pos_target, // Position target from table
  output reg [31:0] gear_num, // Electronic gear numerator
  output reg [31:0] gear_den, // Electronic gear denominator
  output reg [1:0] gain_ptr // Loop-gain set pointer
);
  localparam ST_IDLE = 2'b01;
  localparam ST_HOMING = 2'b10;

  reg [15:0] din_fn_q [0:3];
  reg [15:0] cw_sel_q;
  reg [7:0] mode0_q;
  reg [7:0] mode1_q;
  reg [15:0] kvi_q;
  reg [15:0] sw_cw_q;
  reg ap_q;
  reg ap_wr_q;
  reg [7:0] ap_addr_q;
  reg rd_done_q;
  reg [21:0] fn_act_q;
  reg [21:0] fn_cfg_q;
  reg en_prev_q;
  reg go_prev_q;
  reg qs_lat_q;
  reg qs_arm_q;
  reg [1:0] home_st_q;
  reg [7:0] mode_save_q;
  reg inv_q;
  reg [21:0] fn_act_d;
  reg [21:0] fn_cfg_d;
  reg [15:0] cw_d;
  reg [7:0] mode_base;
  reg [31:0] rmux;
  integer i, j;
  wire rd_stall;
  wire wr_go;
  wire ap_new;
  wire [2:0] spd_idx;
  wire [2:0] pos_idx;
  wire [2:0] gear_idx;
  wire [31:0] spd_val;
  wire [31:0] pos_val;
  wire [31:0] gnum_val;
  wire [31:0] gden_val;
  wire tbl_wr;
  wire en_cfg;
  wire en_rise;
  wire drive_on;
  wire qs_clr;
  wire go_rise;
  wire spd_trq_mode;

  // Reads get one wait state so read data always comes from a flop
  assign rd_stall = ap_q & ~ap_wr_q & ~rd_done_q;
  assign hreadyout = ~rd_stall;
  assign hresp = 1'b0;
  assign ap_new = hsel & htrans[1] & hready;
  assign wr_go = ap_q & ap_wr_q & hready;
  assign tbl_wr = wr_go & ap_addr_q[7:6] != 2'b00;

  always @(posedge ref_clk) begin
    if (rst) begin
      ap_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
      rd_done_q <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      if (hready) begin
        ap_q <= ap_new;
        ap_wr_q <= hwrite;
        ap_addr_q <= haddr[7:0];
        rd_done_q <= 1'b0;
      end else begin
        rd_done_q <= 1'b1;
        hrdata <= rmux;
      end
    end
  end

  always @* begin
    rmux = 32'h0000_0000;
    case (ap_addr_q)
      `DIFM_OFS_DIN0: rmux = {16'h0000, din_fn_q[0]};
      `DIFM_OFS_DIN1: rmux = {16'h0000, din_fn_q[1]};
      `DIFM_OFS_DIN2: rmux = {16'h0000, din_fn_q[2]};
      `DIFM_OFS_DIN3: rmux = {16'h0000, din_fn_q[3]};
      `DIFM_OFS_CWSEL: rmux = {16'h0000, cw_sel_q};
      `DIFM_OFS_MODE: rmux = {16'h0000, mode1_q, mode0_q};
      `DIFM_OFS_KVI: rmux = {16'h0000, kvi_q};
      `DIFM_OFS_SWCW: rmux = {16'h0000, sw_cw_q};
      `DIFM_OFS_STAT: rmux = {home_st_q, qs_lat_q, din, work_mode, 1'b0, ctrl_word};
      `DIFM_OFS_FNACT: rmux = {10'h000, fn_act_q};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      for (i = 0; i < `DIFM_NUM_DIN; i = i + 1) begin
        din_fn_q[i] <= 16'h0000;
      end
      cw_sel_q <= `DIFM_RST_CWSEL;
      mode0_q <= `DIFM_RST_MODE0;
      mode1_q <= `DIFM_RST_MODE1;
      kvi_q <= `DIFM_RST_KVI;
      sw_cw_q <= `DIFM_RST_SWCW;
    end else if (wr_go) begin
      case (ap_addr_q)
        `DIFM_OFS_DIN0: din_fn_q[0] <= hwdata[15:0];
        `DIFM_OFS_DIN1: din_fn_q[1] <= hwdata[15:0];
        `DIFM_OFS_DIN2: din_fn_q[2] <= hwdata[15:0];
        `DIFM_OFS_DIN3: din_fn_q[3] <= hwdata[15:0];
        `DIFM_OFS_CWSEL: cw_sel_q <= hwdata[15:0];
        `DIFM_OFS_MODE: begin
          mode0_q <= hwdata[7:0];
          mode1_q <= hwdata[15:8];
        end
        `DIFM_OFS_KVI: kvi_q <= hwdata[15:0];
        `DIFM_OFS_SWCW: sw_cw_q <= hwdata[15:0];
        default: sw_cw_q <= sw_cw_q;
      endcase
    end
  end

  // Function decode per input; codes with several bits set drive several
  always @* begin
    fn_act_d = 22'h000000;
    fn_cfg_d = 22'h000000;
    for (j = 0; j < `DIFM_NUM_DIN; j = j + 1) begin
      if (din_fn_q[j][`DIFM_CODE_EXT_BIT]) begin
        fn_cfg_d[21:15] = fn_cfg_d[21:15] | din_fn_q[j][6:0];
        fn_act_d[21:15] = fn_act_d[21:15] | (din_fn_q[j][6:0] & {7{din[j]}});
      end else begin
        fn_cfg_d[14:0] = fn_cfg_d[14:0] | din_fn_q[j][14:0];
        fn_act_d[14:0] = fn_act_d[14:0] | (din_fn_q[j][14:0] & {15{din[j]}});
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      fn_act_q <= 22'h000000;
      fn_cfg_q <= 22'h000000;
    end else begin
      fn_act_q <= fn_act_d;
      fn_cfg_q <= fn_cfg_d;
    end
  end

  assign en_cfg = fn_cfg_q[`DIFM_FN_ENABLE];
  assign en_rise = fn_act_q[`DIFM_FN_ENABLE] & ~en_prev_q;
  assign drive_on = ctrl_word[3:0] == `DIFM_CW_ENABLED;
  assign go_rise = fn_act_q[`DIFM_FN_HOMEGO] & ~go_prev_q;
  // Enable edge ends the stop only when an input owns enable
  assign qs_clr = en_cfg ? en_rise : (wr_go & ap_addr_q == `DIFM_OFS_SWCW &
                  hwdata[15:0] == `DIFM_CW_ENABLED & qs_arm_q);

  always @(posedge ref_clk) begin
    if (rst) begin
      en_prev_q <= 1'b0;
      go_prev_q <= 1'b0;
      qs_lat_q <= 1'b0;
      qs_arm_q <= 1'b0;
    end else begin
      en_prev_q <= fn_act_q[`DIFM_FN_ENABLE];
      go_prev_q <= fn_act_q[`DIFM_FN_HOMEGO];
      // Set beats clear so a held stop input keeps the drive stopped
      if (fn_act_q[`DIFM_FN_QSTOP]) begin
        qs_lat_q <= 1'b1;
      end else if (qs_clr) begin
        qs_lat_q <= 1'b0;
      end
      if (~qs_lat_q | qs_clr) begin
        qs_arm_q <= 1'b0;
      end else if (wr_go & ap_addr_q == `DIFM_OFS_SWCW) begin
        qs_arm_q <= hwdata[15:0] == `DIFM_CW_DISABLED;
      end
    end
  end

  always @* begin
    if (en_cfg) begin
      cw_d = fn_act_q[`DIFM_FN_ENABLE] ? cw_sel_q : `DIFM_CW_DISABLED;
    end else begin
      cw_d = sw_cw_q;
    end
    if (fn_act_q[`DIFM_FN_RSTERR]) begin
      cw_d[`DIFM_CW_RSTERR_BIT] = 1'b1;
    end
    if (fn_act_q[`DIFM_FN_ACTCMD]) begin
      cw_d[`DIFM_CW_NEWSP_BIT] = 1'b1;
    end
    if (fn_act_q[`DIFM_FN_QSTOP] | qs_lat_q) begin
      cw_d[`DIFM_CW_QSTOP_BIT] = 1'b0;
    end
    mode_base = fn_act_q[`DIFM_FN_MODESEL] ? mode1_q : mode0_q;
  end

  // Homing borrows the mode and hands it back on origin found
  always @(posedge ref_clk) begin
    if (rst) begin
      home_st_q <= ST_IDLE;
      mode_save_q <= `DIFM_RST_MODE0;
      homing_start <= 1'b0;
    end else begin
      homing_start <= 1'b0;
      case (home_st_q)
        ST_IDLE: begin
          if (go_rise & drive_on) begin
            home_st_q <= ST_HOMING;
            mode_save_q <= mode_base;
            homing_start <= 1'b1;
          end
        end
        ST_HOMING: begin
          if (home_found) begin
            home_st_q <= ST_IDLE;
          end
        end
        default: home_st_q <= ST_IDLE;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_word <= `DIFM_CW_DISABLED;
      work_mode <= `DIFM_RST_MODE0;
      kvi_eff <= `DIFM_RST_KVI;
      fwd_inhibit <= 1'b0;
      rev_inhibit <= 1'b0;
      home_ref <= 1'b0;
      gain_ptr <= 2'b00;
      inv_q <= 1'b0;
    end else begin
      ctrl_word <= cw_d;
      if (home_st_q == ST_HOMING & home_found) begin
        work_mode <= mode_save_q;
      end else if (home_st_q == ST_HOMING) begin
        work_mode <= `DIFM_MODE_HOMING;
      end else begin
        work_mode <= mode_base;
      end
      kvi_eff <= fn_act_q[`DIFM_FN_KVIOFF] ? 16'h0000 : kvi_q;
      // Normally closed wiring: an unconfigured limit never blocks
      fwd_inhibit <= fn_cfg_q[`DIFM_FN_PLIM] & ~fn_act_q[`DIFM_FN_PLIM];
      rev_inhibit <= fn_cfg_q[`DIFM_FN_NLIM] & ~fn_act_q[`DIFM_FN_NLIM];
      home_ref <= fn_act_q[`DIFM_FN_HOME];
      gain_ptr <= {fn_act_q[`DIFM_FN_GAIN1], fn_act_q[`DIFM_FN_GAIN0]};
      inv_q <= fn_act_q[`DIFM_FN_INVDIR];
    end
  end

  assign spd_idx = {fn_act_q[`DIFM_FN_SPD2], fn_act_q[`DIFM_FN_SPD1],
                    fn_act_q[`DIFM_FN_SPD0]};
  assign pos_idx = {fn_act_q[`DIFM_FN_POS2], fn_act_q[`DIFM_FN_POS1],
                    fn_act_q[`DIFM_FN_POS0]};
  assign gear_idx = {fn_act_q[`DIFM_FN_MF2], fn_act_q[`DIFM_FN_MF1],
                     fn_act_q[`DIFM_FN_MF0]};
  assign spd_trq_mode = work_mode == `DIFM_MODE_SPD_P | work_mode == `DIFM_MODE_SPD_N |
                        work_mode == `DIFM_MODE_TRQ_P | work_mode == `DIFM_MODE_TRQ_N;

  difm_table u_spd (.ref_clk(ref_clk), .rst(rst),
    .wr_en(tbl_wr & ap_addr_q[7:5] == `DIFM_TBL_SPD), .wr_idx(ap_addr_q[4:2]),
    .wr_data(hwdata), .rd_idx(spd_idx), .rd_data(spd_val));
  difm_table u_pos (.ref_clk(ref_clk), .rst(rst),
    .wr_en(tbl_wr & ap_addr_q[7:5] == `DIFM_TBL_POS), .wr_idx(ap_addr_q[4:2]),
    .wr_data(hwdata), .rd_idx(pos_idx), .rd_data(pos_val));
  difm_table u_gnum (.ref_clk(ref_clk), .rst(rst),
    .wr_en(tbl_wr & ap_addr_q[7:5] == `DIFM_TBL_GNUM), .wr_idx(ap_addr_q[4:2]),
    .wr_data(hwdata), .rd_idx(gear_idx), .rd_data(gnum_val));
  difm_table u_gden (.ref_clk(ref_clk), .rst(rst),
    .wr_en(tbl_wr & ap_addr_q[7:5] == `DIFM_TBL_GDEN), .wr_idx(ap_addr_q[4:2]),
    .wr_data(hwdata), .rd_idx(gear_idx), .rd_data(gden_val));

  always @(posedge ref_clk) begin
    if (rst) begin
      speed_cmd <= 32'h0000_0000;
      pos_target <= 32'h0000_0000;
      gear_num <= 32'h0000_0000;
      gear_den <= 32'h0000_0000;
    end else begin
      speed_cmd <= (inv_q & spd_trq_mode) ? (32'h0000_0000 - spd_val) : spd_val;
      pos_target <= pos_val;
      gear_num <= gnum_val;
      gear_den <= gden_val;
    end
  end
endmodule

// ===== difm_top_test.sv
// Purpose: self-checking bench for difm_top against an integer model
// Assumes: switch model drives din, master speaks AHB-Lite
// Notes: inputs held six cycles so every output path has settled
`timescale 1ns/10ps
module difm_top_test;
  // Codes per phase, entry 0 in the low bits
  localparam [319:0] CS = {16'h8040, 16'h8010, 16'h8008, 16'h8004, 16'h8020, 16'h8002,
    16'h0800, 16'h0400, 16'h0080, 16'h8001, 16'h0200, 16'h0100, 16'h4000, 16'h0040,
    16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
  localparam [47:0] RA = {8'hf0, 8'h1c, 8'h18, 8'h10, 8'h14, 8'h00};
  localparam [191:0] RV = {96'h0, 32'h0000000f, 32'h0000fcfd, 32'h0};
  reg ref_clk, rst, hsel, hwrite, home_found;
  reg [31:0] haddr, hwdata, lfsr, rdat;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [3:0] press, nc;
  reg [31:0] tbl [0:31];
  reg [15:0] code [0:3];
  reg [15:0] swcw, kvi;
  wire [31:0] hrdata, speed_cmd, pos_target, gear_num, gear_den;
  wire hreadyout, hresp, fwd_inhibit, rev_inhibit, home_ref, homing_start;
  wire [15:0] ctrl_word, kvi_eff;
  wire [7:0] work_mode;
  wire [1:0] gain_ptr;
  wire [3:0] din;
  integer fails, comparisons, i, k, m, hs_n;
  difm_top difm_top_i (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .din, .home_found, .ctrl_word,
    .work_mode, .kvi_eff, .fwd_inhibit, .rev_inhibit, .home_ref, .homing_start,
    .speed_cmd, .pos_target, .gear_num, .gear_den, .gain_ptr);
  difm_switch difm_switch_i (.ref_clk, .press, .nc, .din);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk)
    if (homing_start === 1'b1)
      hs_n = hs_n + 1;
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task finish_test;
    begin
      if (fails == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge ref_clk);
  endtask
  // Level at negedge equals what the next rising edge samples
  task bw;
    begin
      do @(negedge ref_clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
      @(posedge ref_clk);
    end
  endtask
  task xf(input w, input [7:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      bw;
      htrans <= 2'h0;
      hwdata <= d;
      bw;
    end
  endtask
  task cfg(input [63:0] c);
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        code[j] = c[j*16 +: 16];
        xf(1'b1, {j[5:0], 2'b00}, {16'h0, c[j*16 +: 16]});
      end
    end
  endtask
  task st(input [3:0] p, input [15:0] e);
    begin
      press <= p;
      wt(6);
      chk("cw", ctrl_word, e);
    end
  endtask
  task mcheck;
    integer j, t;
    reg [21:0] f, g;
    reg [3:0] dv;
    reg [15:0] cw;
    reg [31:0] sp;
    begin
      dv = press ^ nc;
      f = 22'h0;
      g = 22'h0;
      for (j = 0; j < 4; j = j + 1) begin
        t = code[j][15] ? {code[j][6:0], 15'h0} : code[j][14:0];
        g = g | t[21:0];
        if (dv[j])
          f = f | t[21:0];
      end
      cw = g[0] ? (f[0] ? 16'h000f : 16'h0006) : swcw;
      cw = cw | (f[1] ? 16'h0080 : 16'h0) | (f[14] ? 16'h0010 : 16'h0);
      chk("cw", ctrl_word, cw);
      chk("mode", work_mode, f[2] ? 8'hfc : 8'hfd);
      chk("kvi", kvi_eff, f[3] ? 16'h0 : kvi);
      chk("fwd", fwd_inhibit, g[4] & ~f[4]);
      chk("rev", rev_inhibit, g[5] & ~f[5]);
      chk("home", home_ref, f[6]);
      sp = tbl[{2'h0, f[15], f[9], f[8]}];
      chk("spd", speed_cmd, f[7] ? -sp : sp);
      chk("pos", pos_target, tbl[{2'h1, f[16], f[11], f[10]}]);
      chk("gnum", gear_num, tbl[{2'h2, f[19:17]}]);
      chk("gden", gear_den, tbl[{2'h3, f[19:17]}]);
      chk("gain", gain_ptr, f[21:20]);
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails = fails + 1;
    finish_test;
  end
  initial begin
    fails = 0;
    comparisons = 0;
    hs_n = 0;
    lfsr = 32'h4e13;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    home_found = 1'b0;
    press = 4'h0;
    nc = 4'h0;
    wt(10);
    chk("cw", ctrl_word, 16'h0006);
    chk("mode", work_mode, 8'hfd);
    rst <= 1'b0;
    hsel <= 1'b1;
    wt(1);
    xf(1'b1, 8'hf0, 32'hffffffff);
    for (i = 0; i < 6; i = i + 1) begin
      xf(1'b0, RA[i*8 +: 8], 32'h0);
      chk("reg", rdat, RV[i*32 +: 32]);
    end
    lfsr = nxt(lfsr);
    kvi = lfsr[15:0];
    swcw = 16'h002f;
    xf(1'b1, 8'h18, {16'h0, kvi});
    xf(1'b1, 8'h1c, {16'h0, swcw});
    for (i = 0; i < 32; i = i + 1) begin
      lfsr = nxt(lfsr);
      tbl[i] = lfsr;
      xf(1'b1, 8'h40 + {i[5:0], 2'b00}, lfsr);
    end
    for (k = 0; k < 5; k = k + 1) begin
      nc <= (k == 1) ? 4'h3 : 4'h0;
      cfg(CS[k*64 +: 64]);
      xf(1'b0, 8'h0c, 32'h0);
      chk("code", rdat, {16'h0, code[3]});
      for (m = 0; m < 12; m = m + 1) begin
        lfsr = nxt(lfsr);
        press <= lfsr[3:0];
        wt(6);
        mcheck;
      end
    end
    // Random leftovers could latch a stop while the new codes land
    press <= 4'h0;
    cfg(64'h0000_0000_1000_0001);
    st(4'h1, 16'h000f);
    st(4'h3, 16'h000b);
    st(4'h1, 16'h000b);
    press <= 4'h0;
    wt(6);
    st(4'h1, 16'h000f);
    cfg(64'h0000_0000_1000_0000);
    xf(1'b1, 8'h1c, 32'h000f);
    st(4'h2, 16'h000b);
    st(4'h0, 16'h000b);
    xf(1'b1, 8'h1c, 32'h000f);
    st(4'h0, 16'h000b);
    xf(1'b1, 8'h1c, 32'h0006);
    xf(1'b1, 8'h1c, 32'h000f);
    st(4'h0, 16'h000f);
    cfg(64'h0000_0004_2000_0001);
    st(4'h6, 16'h0006);
    chk("hstart", hs_n, 32'h0);
    press <= 4'h5;
    wt(6);
    press <= 4'h7;
    wt(6);
    chk("hstart", hs_n, 32'h1);
    chk("mode", work_mode, 8'h06);
    home_found <= 1'b1;
    wt(1);
    home_found <= 1'b0;
    wt(6);
    chk("mode", work_mode, 8'hfc);
    finish_test;
  end
endmodule
